/* rtl/fp_memory_format_translator.sv */
// fp register to/from memory and integer register format translator
// Notes on behaviour
// RULE1 - register entries are full 82-bit values
// RULE2 - paired loads target opposite-parity registers
// RULE3 - paired loads may post-increment base
// RULE4 - stores need matching source type
// RULE5 - failed speculative load writes deferred value
// RULE6 - deferred value store faults, spill excepted
// RULE7 - spill/fill move raw contents, 16 bytes
// RULE8 - loads/stores honour both byte orders
// RULE9 - extended image is 80 bits, own ordering
// RULE10 - integer token maps to deferred value
// RULE11 - int transfers reuse memory conversion
// RULE12 - integer load sets 0x1003E exponent
// RULE13 - exp transfer builds sign, exponent, fixed significand
// RULE14 - deferred value read sets integer token
// RULE15 - other reads give significand or sign/exponent
// RULE16 - double inf/nan gets exponent 0x1FFFF
// RULE17 - extended inf/nan gets exponent 0x1FFFF
// RULE18 - double denormal gets exponent 0x0FC01
// RULE19 - normal loads rebias and set integer bit
// RULE20 - normal stores rebias and truncate
`timescale 1ns/10ps
module fp_memory_format_translator
  import fp_xlate_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic op_valid,
  input wire fp_op_t op_code,
  input wire logic big_endian,
  input wire logic spec_fail,
  input wire logic pair,
  input wire logic post_inc,
  input wire logic [63:0] base_addr,
  input wire logic [63:0] inc_amount,
  input wire logic [127:0] mem_data,
  input wire logic [63:0] int_data,
  input wire logic int_token,
  input wire logic [81:0] fp_src,
  output logic res_valid,
  output logic [81:0] fp_result_lo,
  output logic [81:0] fp_result_hi,
  output logic fp_write,
  output logic [127:0] mem_wdata,
  output logic mem_write,
  output logic [63:0] int_result,
  output logic int_token_out,
  output logic int_write,
  output logic token_fault,
  output logic [63:0] base_addr_out,
  output logic base_write
);
  // byte swap of a 128-bit word
  function automatic logic [127:0] swap16(input logic [127:0] v);
    logic [127:0] r;
    r = '0;
    for (int i = 0; i < 16; i++) r[8*i +: 8] = v[8*(15-i) +: 8];
    return r;
  endfunction : swap16
  function automatic logic [63:0] swap8(input logic [63:0] v);
    logic [63:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) r[8*i +: 8] = v[8*(7-i) +: 8];
    return r;
  endfunction : swap8
  function automatic logic [31:0] swap4(input logic [31:0] v);
    logic [31:0] r;
    r = '0;
    for (int i = 0; i < 4; i++) r[8*i +: 8] = v[8*(3-i) +: 8];
    return r;
  endfunction : swap4
  function automatic logic [79:0] swap10(input logic [79:0] v);
    logic [79:0] r;
    r = '0;
    for (int i = 0; i < 10; i++) r[8*i +: 8] = v[8*(9-i) +: 8];
    return r;
  endfunction : swap10
  // single image to register
  function automatic logic [81:0] ld_sgl(input logic [31:0] m);
    logic [16:0] e;
    e = 17'(m[30:23]) - EXP_BIAS_SGL + EXP_BIAS_REG;
    if (m[30:23] == 8'hFF) return {m[31], EXP_SPECIAL, 1'b1, m[22:0], 40'h0000000000};
    else if (m[30:23] == 8'h00 && m[22:0] == 23'h000000) return {m[31], 17'h00000, 64'h0};
    else if (m[30:23] == 8'h00) return {m[31], EXP_SGL_DENORM, 1'b0, m[22:0], 40'h0000000000};
    else return {m[31], e, 1'b1, m[22:0], 40'h0000000000};
  endfunction : ld_sgl
  // double image to register
  function automatic logic [81:0] ld_dbl(input logic [63:0] m);
    logic [16:0] e;
    e = 17'(m[62:52]) - EXP_BIAS_DBL + EXP_BIAS_REG;
    if (m[62:52] == 11'h7FF) return {m[63], EXP_SPECIAL, 1'b1, m[51:0], 11'h000}; // see RULE16
    else if (m[62:52] == 11'h000 && m[51:0] == 52'h0) return {m[63], 17'h00000, 64'h0};
    else if (m[62:52] == 11'h000) return {m[63], EXP_DBL_DENORM, 1'b0, m[51:0], 11'h000}; // see RULE18
    else return {m[63], e, 1'b1, m[51:0], 11'h000}; // see RULE19
  endfunction : ld_dbl
  // register to single image
  function automatic logic [31:0] st_sgl(input logic [81:0] f);
    logic [16:0] e;
    e = f[80:64] - EXP_BIAS_REG + EXP_BIAS_SGL;
    if (f[80:64] == EXP_SPECIAL) return {f[81], 8'hFF, f[62:40]};
    else if (f[63] == 1'b0) return {f[81], 8'h00, f[62:40]};
    else return {f[81], e[7:0], f[62:40]}; // see RULE20
  endfunction : st_sgl
  function automatic logic [63:0] st_dbl(input logic [81:0] f);
    logic [16:0] e;
    e = f[80:64] - EXP_BIAS_REG + EXP_BIAS_DBL;
    if (f[80:64] == EXP_SPECIAL) return {f[81], 11'h7FF, f[62:11]};
    else if (f[63] == 1'b0) return {f[81], 11'h000, f[62:11]};
    else return {f[81], e[10:0], f[62:11]}; // see RULE20
  endfunction : st_dbl
  // extended image to register
  function automatic logic [81:0] ld_ext(input logic [79:0] m);
    if (m[78:64] == 15'h7FFF) return {m[79], EXP_SPECIAL, m[63:0]}; // see RULE17
    else if (m[78:64] == 15'h0000) return {m[79], 17'h00000, m[63:0]};
    else return {m[79], 17'(m[78:64]) - EXP_BIAS_EXT + EXP_BIAS_REG, m[63:0]};
  endfunction : ld_ext
  function automatic logic [79:0] st_ext(input logic [81:0] f);
    logic [16:0] e;
    e = f[80:64] - EXP_BIAS_REG + EXP_BIAS_EXT;
    if (f[80:64] == EXP_SPECIAL) return {f[81], 15'h7FFF, f[63:0]};
    else if (f[80:64] == 17'h00000) return {f[81], 15'h0000, f[63:0]};
    else return {f[81], e[14:0], f[63:0]};
  endfunction : st_ext

  // little-endian view of incoming memory data, see RULE8
  wire [127:0] mem_le = big_endian ? swap16(mem_data) : mem_data;
  wire [31:0] m_s_lo = big_endian ? swap4(mem_data[31:0]) : mem_data[31:0];
  wire [31:0] m_s_hi = big_endian ? swap4(mem_data[63:32]) : mem_data[63:32];
  wire [63:0] m_d_lo = big_endian ? swap8(mem_data[63:0]) : mem_data[63:0];
  wire [63:0] m_d_hi = big_endian ? swap8(mem_data[127:64]) : mem_data[127:64];
  wire [79:0] m_ext = big_endian ? swap10(mem_data[79:0]) : mem_data[79:0]; // see RULE9
  wire src_deferred_fault_fp_value = (fp_src == DEFERRED_FAULT_FP_VALUE);
  // integer-file transfers turn a set token into the deferred value, see RULE10
  wire int_tok_nat = int_token && (op_code inside {op_load_single, op_load_double, load_integer_to_fp_reg,
                                                   op_set_exp});
  wire is_load = op_code inside {op_load_single, op_load_double, op_load_extended, load_integer_to_fp_reg,
                                 op_fill, op_set_exp};
  wire is_store = op_code inside {op_store_single, op_store_double, op_store_extended, store_integer_image,
                                  op_spill, op_get_exp};
  logic [81:0] lo_d, hi_d;
  logic [127:0] wdata_d;
  logic [63:0] ires_d;
  logic itok_d, iwr_d, mwr_d, flt_d;

  // integer-sourced loads take their memory image on mem_data, see RULE11
  always_comb begin
    lo_d = '0;
    hi_d = '0;
    case (op_code)
      op_load_single: begin
        lo_d = ld_sgl(m_s_lo);
        hi_d = ld_sgl(m_s_hi);
      end
      op_load_double: begin
        lo_d = ld_dbl(m_d_lo);
        hi_d = ld_dbl(m_d_hi);
      end
      op_load_extended: lo_d = ld_ext(m_ext);
      load_integer_to_fp_reg: begin
        lo_d = {1'b0, EXP_INTEGER, m_d_lo}; // see RULE12
        hi_d = {1'b0, EXP_INTEGER, m_d_hi}; // see RULE3
      end
      op_fill: lo_d = mem_le[81:0]; // see RULE7
      op_set_exp: lo_d = {int_data[17], int_data[16:0], SIG_EXP_XFER}; // see RULE13
      default: lo_d = '0;
    endcase
    if (spec_fail || int_tok_nat) begin
      lo_d = DEFERRED_FAULT_FP_VALUE; // see RULE5
      hi_d = DEFERRED_FAULT_FP_VALUE; // see RULE10
    end
  end

  always_comb begin
    wdata_d = '0;
    ires_d = '0;
    itok_d = 1'b0;
    case (op_code)
      op_store_single: wdata_d = {96'h0, big_endian ? swap4(st_sgl(fp_src)) : st_sgl(fp_src)}; // see RULE8
      op_store_double: wdata_d = {64'h0, big_endian ? swap8(st_dbl(fp_src)) : st_dbl(fp_src)};
      op_store_extended: wdata_d = {48'h0, big_endian ? swap10(st_ext(fp_src)) : st_ext(fp_src)};
      store_integer_image: wdata_d = {64'h0, big_endian ? swap8(fp_src[63:0]) : fp_src[63:0]};
      op_spill: wdata_d = big_endian ? swap16({46'h0, fp_src}) : {46'h0, fp_src}; // see RULE7
      op_get_exp: ires_d = src_deferred_fault_fp_value ? 64'(EXP_DEFERRED_FAULT_FP_VALUE) : 64'({fp_src[81], fp_src[80:64]}); // see RULE15
      default: wdata_d = '0;
    endcase
    if (src_deferred_fault_fp_value && op_code == op_get_exp) itok_d = 1'b1; // see RULE14
  end

  // faulting stores never reach memory, see RULE6
  assign flt_d = op_valid && src_deferred_fault_fp_value && is_store && op_code != op_spill && op_code != op_get_exp;
  assign mwr_d = op_valid && is_store && op_code != op_get_exp && !flt_d;
  assign iwr_d = op_valid && op_code == op_get_exp; // see RULE10
  wire base_wr_d = op_valid && pair && post_inc && is_load; // see RULE3
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      res_valid <= 1'b0;
      fp_result_lo <= '0;
      fp_result_hi <= '0;
      fp_write <= 1'b0;
      mem_wdata <= '0;
      mem_write <= 1'b0;
      int_result <= '0;
      int_token_out <= 1'b0;
      int_write <= 1'b0;
      token_fault <= 1'b0;
      base_addr_out <= '0;
      base_write <= 1'b0;
    end else begin
      res_valid <= op_valid;
      fp_result_lo <= lo_d; // see RULE1
      fp_result_hi <= pair ? hi_d : '0;
      fp_write <= op_valid && is_load;
      mem_wdata <= wdata_d;
      mem_write <= mwr_d;
      int_result <= ires_d;
      int_token_out <= itok_d;
      int_write <= iwr_d;
      token_fault <= flt_d;
      base_addr_out <= base_addr + inc_amount;
      base_write <= base_wr_d;
    end
  end
endmodule : fp_memory_format_translator

/* rtl/fp_xlate_pkg.sv */
// constants and types for the fp memory format translator
package fp_xlate_pkg;
  localparam int REG_W = 82;
  localparam int SIG_W = 64;
  localparam int EXP_W = 17;
  localparam int SIGN_POS = 81;
  localparam int EXP_HI = 80;
  localparam int EXP_LO = 64;
  localparam logic [16:0] EXP_BIAS_REG = 17'h0FFFF;
  localparam logic [16:0] EXP_BIAS_SGL = 17'h0007F;
  localparam logic [16:0] EXP_BIAS_DBL = 17'h003FF;
  localparam logic [16:0] EXP_BIAS_EXT = 17'h03FFF;
  localparam logic [16:0] EXP_SPECIAL = 17'h1FFFF;
  localparam logic [16:0] EXP_DEFERRED_FAULT_FP_VALUE = 17'h1FFFE;
  localparam logic [16:0] EXP_INTEGER = 17'h1003E;
  localparam logic [16:0] EXP_DBL_DENORM = 17'h0FC01;
  localparam logic [16:0] EXP_SGL_DENORM = 17'h0FF81;
  localparam logic [63:0] SIG_EXP_XFER = 64'h8000000000000000;
  localparam logic [81:0] DEFERRED_FAULT_FP_VALUE = {1'b0, 17'h1FFFE, 64'h0000000000000000};
  localparam int EXT_W = 80;
  localparam int SLOT_W = 128;
  typedef enum logic [3:0] {
    op_load_single, op_load_double, op_load_extended, load_integer_to_fp_reg, op_fill,
    op_store_single, op_store_double, op_store_extended, store_integer_image, op_spill,
    op_set_exp, op_get_exp
  } fp_op_t;
endpackage : fp_xlate_pkg

/* verif/mem_slot_model.sv */
// load/store path model holding one 16-byte memory slot
`timescale 1ns/10ps
module mem_slot_model (
  input wire logic clock,
  input wire logic mem_write,
  input wire logic [127:0] mem_wdata,
  output logic [127:0] slot_q
);
  always_ff @(posedge clock) begin
    if (mem_write) slot_q <= mem_wdata;
  end
endmodule : mem_slot_model

/* verif/fp_xlate_props.sv */
// port assertions for the fp format translator
`timescale 1ns/10ps
module fp_xlate_props
  import fp_xlate_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic op_valid,
  input wire fp_op_t op_code,
  input wire logic spec_fail,
  input wire logic [63:0] int_data,
  input wire logic int_token,
  input wire logic [81:0] fp_src,
  input wire logic res_valid,
  input wire logic [81:0] fp_result_lo,
  input wire logic mem_write,
  input wire logic [63:0] int_result,
  input wire logic int_token_out,
  input wire logic token_fault
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence nat_store_s;
    op_valid && fp_src == DEFERRED_FAULT_FP_VALUE &&
    op_code inside {op_store_single, op_store_double, op_store_extended, store_integer_image};
  endsequence
  sequence spill_s; op_valid && op_code == op_spill; endsequence
  result_delay_a: assert property (op_valid |=> res_valid) else $error("result late");
  idle_quiet_a: assert property (!op_valid |=> !res_valid && !mem_write) else $error("spurious output");
  nat_fault_a: assert property (nat_store_s |=> token_fault && !mem_write) else $error("no fault");
  spill_ok_a: assert property (spill_s |=> mem_write && !token_fault) else $error("spill fault");
  spec_nat_a: assert property (op_valid && spec_fail && op_code == op_load_double |=>
    fp_result_lo == DEFERRED_FAULT_FP_VALUE) else $error("spec value");
  set_exp_a: assert property (op_valid && op_code == op_set_exp && !int_token && !spec_fail |=>
    fp_result_lo == {$past(int_data[17:0]), SIG_EXP_XFER}) else $error("set exp");
  token_nat_a: assert property (op_valid && op_code == op_set_exp && int_token |=>
    fp_result_lo == DEFERRED_FAULT_FP_VALUE) else $error("token value");
  get_exp_a: assert property (op_valid && op_code == op_get_exp && fp_src != DEFERRED_FAULT_FP_VALUE |=>
    int_result == {46'h0, $past(fp_src[81:64])} && !int_token_out) else $error("get exp");
endmodule : fp_xlate_props
bind fp_memory_format_translator fp_xlate_props props_i (.clock(clock), .rst_b(rst_b), .op_valid(op_valid),
  .op_code(op_code), .spec_fail(spec_fail), .int_data(int_data), .int_token(int_token), .fp_src(fp_src),
  .res_valid(res_valid), .fp_result_lo(fp_result_lo), .mem_write(mem_write), .int_result(int_result),
  .int_token_out(int_token_out), .token_fault(token_fault));

/* verif/tb.sv */
// self-checking bench for the fp format translator
`timescale 1ns/10ps
module tb;
  import fp_xlate_pkg::*;
  logic clock = 0, rst_b = 0, op_valid = 0, big_endian = 0, spec_fail = 0, pair = 0, post_inc = 0, int_token = 0;
  fp_op_t op_code = op_load_single;
  logic [63:0] base_addr = '0, inc_amount = '0, int_data = '0, int_result, base_addr_out;
  logic [127:0] mem_data = '0, mem_wdata, slot_q;
  logic [81:0] fp_src = '0, fp_result_lo, fp_result_hi;
  logic res_valid, fp_write, mem_write, int_token_out, int_write, token_fault, base_write;
  int err_count = 0, tests_run = 0;
  fp_memory_format_translator dut (.clock(clock), .rst_b(rst_b), .op_valid(op_valid), .op_code(op_code),
    .big_endian(big_endian), .spec_fail(spec_fail), .pair(pair), .post_inc(post_inc), .base_addr(base_addr),
    .inc_amount(inc_amount), .mem_data(mem_data), .int_data(int_data), .int_token(int_token), .fp_src(fp_src),
    .res_valid(res_valid), .fp_result_lo(fp_result_lo), .fp_result_hi(fp_result_hi), .fp_write(fp_write),
    .mem_wdata(mem_wdata), .mem_write(mem_write), .int_result(int_result), .int_token_out(int_token_out),
    .int_write(int_write), .token_fault(token_fault), .base_addr_out(base_addr_out), .base_write(base_write));
  mem_slot_model slot_i (.clock(clock), .mem_write(mem_write), .mem_wdata(mem_wdata), .slot_q(slot_q));
  always #2.5 clock = ~clock;
  task chk(input logic [127:0] s, input logic [127:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, s, e);
    end
  endtask : chk
  // flags: big_endian, spec_fail, pair, post_inc, int_token
  task go(input fp_op_t c, input logic [127:0] m, input logic [81:0] f, input logic [4:0] fl);
    @(posedge clock);
    op_valid <= 1'b1;
    op_code <= c;
    mem_data <= m;
    int_data <= m[63:0];
    fp_src <= f;
    {big_endian, spec_fail, pair, post_inc, int_token} <= fl;
    base_addr <= 64'h1000;
    inc_amount <= 64'h10;
    @(posedge clock);
    op_valid <= 1'b0;
    #1;
    chk(res_valid, 1'b1);
  endtask : go
  task int_loads;
    go(load_integer_to_fp_reg, 128'h0123456789ABCDEF, '0, 5'h00);
    chk(fp_result_lo, {1'b0, EXP_INTEGER, 64'h0123456789ABCDEF});
    // paired big-endian load with base post-increment
    go(load_integer_to_fp_reg, 128'hFEDCBA98_0123456789ABCDEF, '0, 5'h16);
    chk(fp_result_lo, {1'b0, EXP_INTEGER, 64'hEFCDAB8967452301});
    chk(fp_result_hi, {1'b0, EXP_INTEGER, 64'h98BADCFE00000000});
    chk({base_write, base_addr_out}, {1'b1, 64'h1010});
    go(op_load_double, 128'h3FF0000000000000, '0, 5'h01);
    chk(fp_result_lo, DEFERRED_FAULT_FP_VALUE);
  endtask : int_loads
  task dbl_loads;
    go(op_load_double, 128'h3FF0000000000000, '0, 5'h00);
    chk(fp_result_lo, {1'b0, EXP_BIAS_REG, SIG_EXP_XFER});
    go(op_load_double, 128'hFFF8000000000000, '0, 5'h00);
    chk(fp_result_lo, {1'b1, EXP_SPECIAL, 64'hC000000000000000});
    go(op_load_double, 128'h0000000000000001, '0, 5'h00);
    chk(fp_result_lo, {1'b0, EXP_DBL_DENORM, 64'h0000000000000800});
    go(op_load_extended, {48'h0, 16'h7FFF, 64'h8000000000000001}, '0, 5'h00);
    chk(fp_result_lo, {1'b0, EXP_SPECIAL, 64'h8000000000000001});
    go(op_load_double, 128'h3FF0000000000000, '0, 5'h08);
    chk({fp_write, fp_result_lo}, {1'b1, DEFERRED_FAULT_FP_VALUE});
    go(op_load_single, 128'h40000000_3F800000, '0, 5'h04);
    chk(fp_result_lo, {1'b0, EXP_BIAS_REG, 64'h8000000000000000});
    chk(fp_result_hi, {1'b0, 17'h10000, 64'h8000000000000000});
  endtask : dbl_loads
  task stores;
    // source holds a double, matching the store type
    go(op_store_double, '0, {1'b0, EXP_BIAS_REG, SIG_EXP_XFER}, 5'h00);
    chk({mem_write, mem_wdata[63:0]}, {1'b1, 64'h3FF0000000000000});
    go(op_store_single, '0, DEFERRED_FAULT_FP_VALUE, 5'h00);
    chk({token_fault, mem_write}, 2'b10);
    go(op_spill, '0, DEFERRED_FAULT_FP_VALUE, 5'h00);
    chk({token_fault, mem_write}, 2'b01);
    @(posedge clock);
    #1;
    go(op_fill, slot_q, '0, 5'h00);
    chk(fp_result_lo, DEFERRED_FAULT_FP_VALUE);
    go(op_store_single, '0, {1'b0, EXP_BIAS_REG, 64'h8000000000000000}, 5'h10);
    chk(mem_wdata, 128'h0000803F);
    go(op_store_extended, '0, {1'b1, EXP_BIAS_REG, 64'h8000000000000000}, 5'h00);
    chk(mem_wdata, {48'h0, 16'hBFFF, 64'h8000000000000000});
    go(store_integer_image, '0, {1'b0, EXP_INTEGER, 64'h0123456789ABCDEF}, 5'h00);
    chk(mem_wdata, {64'h0, 64'h0123456789ABCDEF});
    go(op_spill, '0, {1'b1, EXP_BIAS_REG, 64'h0123456789ABCDEF}, 5'h10);
    chk(mem_wdata[127:64], 64'hEFCDAB8967452301);
    @(posedge clock);
    #1;
    go(op_fill, slot_q, '0, 5'h10);
    chk(fp_result_lo, {1'b1, EXP_BIAS_REG, 64'h0123456789ABCDEF});
  endtask : stores
  task xfers;
    go(op_set_exp, 128'h3FFFF, '0, 5'h00);
    chk(fp_result_lo, {1'b1, EXP_SPECIAL, SIG_EXP_XFER});
    go(op_set_exp, 128'h3FFFF, '0, 5'h01);
    chk(fp_result_lo, DEFERRED_FAULT_FP_VALUE);
    go(op_get_exp, '0, DEFERRED_FAULT_FP_VALUE, 5'h00);
    chk({int_write, int_token_out, int_result}, {2'b11, 64'h1FFFE});
    go(op_get_exp, '0, {1'b1, EXP_BIAS_REG, SIG_EXP_XFER}, 5'h00);
    chk({int_write, int_token_out, int_result}, {2'b10, 64'h2FFFF});
  endtask : xfers
  task results;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  initial begin
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    int_loads();
    dbl_loads();
    stores();
    xfers();
    results();
  end
  // about 55 cycles of work, ample margin
  initial begin
    #5000;
    err_count++;
    results();
  end
endmodule : tb
